// [hw/sar_adc_readout_regs.svh]
// Purpose: timing counts, fixed words and sizes for the converter readout logic
// Assumes: mclk at 10 MHz
// Notes: definitions only
`ifndef SAR_ADC_READOUT_REGS_SVH
`define SAR_ADC_READOUT_REGS_SVH

`define RESULT_BITS 16
`define MCLK_PERIOD_PS 100000
// conversion must end within this time, so it rounds down, floored at one cycle
`define CONV_TIME_NS 63
`define CONV_CYCLES_RAW ((`CONV_TIME_NS * 1000) / `MCLK_PERIOD_PS)
`define CONV_CYCLES ((`CONV_CYCLES_RAW < 1) ? 1 : `CONV_CYCLES_RAW)
// acquisition is a least time, so it rounds up
`define ACQ_TIME_PS 27700
`define ACQ_CYCLES ((`ACQ_TIME_PS + `MCLK_PERIOD_PS - 1) / `MCLK_PERIOD_PS)
`define STABILISE_TIME_MS 20
`define PATTERN_ONE_LANE 16'hA07F
`define PATTERN_TWO_LANE 16'hCC3F
`define DISCARD_COUNT 2'h2
`define EDGES_ONE_LANE 5'h10
`define EDGES_TWO_LANE 5'h08
`define FIFO_DEPTH 32

`endif

// [hw/sar_adc_readout_pkg.sv]
// Purpose: types shared by the converter readout logic
// Assumes: 16-bit results
// Notes: none
package sar_adc_readout_pkg;

    typedef struct packed {
        logic invalid;
        logic [15:0] data;
    } result_word_type;

    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_BUSY,
        CONV_PUSH,
        CONV_ACQUIRE
    } conv_phase_type;

    typedef struct packed {
        logic cnv_prev;
        logic rclk_prev;
        conv_phase_type phase;
        logic [7:0] cnt;
        logic [1:0] discard;
        result_word_type pending;
        logic loaded;
        logic dual;
        logic [15:0] shift;
        logic [4:0] edges;
        logic lane_a;
        logic lane_b;
        logic echo;
        logic lane_a_en;
        logic lane_b_en;
        logic echo_en;
        logic invalid;
    } readout_state_type;

endpackage

// [hw/bit_sync.sv]
// Purpose: two-flop synchroniser for a group of level inputs
// Assumes: inputs are levels from outside the mclk domain
// Notes: only the second stage is visible
`timescale 1ns/1ps
module bit_sync #(
    parameter int WIDTH = 5
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_type;

    sync_state_type state_ff;
    sync_state_type nxt_state;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.stage1 = async_in;
        nxt_state.stage2 = state_ff.stage1;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign sync_out = state_ff.stage2;
endmodule

// [hw/result_fifo.sv]
// Purpose: result buffer between conversion and serial readout
// Assumes: one clock; flush empties it in one cycle
// Notes: pop and push may happen in the same cycle
`timescale 1ns/1ps
module result_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 32
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

    typedef struct packed {
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [CNT_W-1:0] count;
    } fifo_state_type;

    fifo_state_type state_ff;
    fifo_state_type nxt_state;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign in_ready = (state_ff.count != FULL_COUNT);
    assign out_valid = (state_ff.count != '0);
    assign out_data = mem[state_ff.rd_ptr];
    assign push = in_valid && in_ready && !flush;
    assign pop = out_valid && out_ready && !flush;

    always_comb begin
        nxt_state = state_ff;
        if (flush) begin
            nxt_state = '0;
        end else begin
            if (push) begin
                nxt_state.wr_ptr = (state_ff.wr_ptr == LAST_PTR) ? '0 : state_ff.wr_ptr + 1'b1;
            end
            if (pop) begin
                nxt_state.rd_ptr = (state_ff.rd_ptr == LAST_PTR) ? '0 : state_ff.rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                nxt_state.count = state_ff.count + 1'b1;
            end else if (pop && !push) begin
                nxt_state.count = state_ff.count - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[state_ff.wr_ptr] <= in_data;
        end
    end
endmodule

// [hw/sar_adc_serial_readout.sv]
// Purpose: conversion control and serial readout of a 16-bit SAR converter
// Assumes: analog_code is the front end's settled code, read at the start edge
// Notes: readout clock is sampled by mclk; its period must span several mclk
`timescale 1ns/1ps
`include "sar_adc_readout_regs.svh"
module sar_adc_serial_readout
    import sar_adc_readout_pkg::*;
#(
    parameter int FIFO_DEPTH = `FIFO_DEPTH,
    parameter int CONV_CYCLES = `CONV_CYCLES,
    parameter int ACQ_CYCLES = `ACQ_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic power_down_n,
    input wire logic convert_start,
    input wire logic readout_clock,
    input wire logic dual_lane_select,
    input wire logic pattern_force,
    input wire logic [15:0] analog_code,
    output logic lane_a_data,
    output logic lane_a_en,
    output logic lane_b_data,
    output logic lane_b_en,
    output logic echoed_clock_out,
    output logic echoed_clock_en,
    output logic result_invalid
);
    localparam logic [7:0] CONV_LOAD = 8'(CONV_CYCLES - 1);
    localparam logic [7:0] ACQ_LOAD = 8'((ACQ_CYCLES < 1) ? 0 : ACQ_CYCLES - 1);

    logic [4:0] pins_sync;
    logic pd_n_s;
    logic cnv_s;
    logic rclk_s;
    logic dual_s;
    logic pat_s;

    bit_sync #(
        .WIDTH(5)
    ) u_pin_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .async_in({power_down_n, convert_start, readout_clock, dual_lane_select,
                   pattern_force}),
        .sync_out(pins_sync)
    );

    assign pd_n_s = pins_sync[4];
    assign cnv_s = pins_sync[3];
    assign rclk_s = pins_sync[2];
    assign dual_s = pins_sync[1];
    assign pat_s = pins_sync[0];

    readout_state_type state_ff;
    readout_state_type nxt_state;

    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    result_word_type fifo_out_word;
    logic fifo_flush;

    result_fifo #(
        .WIDTH($bits(result_word_type)),
        .DEPTH(FIFO_DEPTH)
    ) u_result_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .flush(fifo_flush),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(state_ff.pending),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_word)
    );

    logic cnv_rise;
    logic rclk_edge;
    logic [15:0] conv_word;
    logic [15:0] shifted;
    logic [4:0] edges_total;
    logic [4:0] edges_next;

    // hold conversions back while the buffer is full; flush on power-down
    assign fifo_flush = !pd_n_s;
    assign fifo_in_valid = (state_ff.phase == CONV_PUSH) && pd_n_s;
    assign fifo_out_ready = pd_n_s && !state_ff.loaded;

    assign cnv_rise = cnv_s && !state_ff.cnv_prev;
    assign rclk_edge = (rclk_s != state_ff.rclk_prev);

    // fixed word replaces the result while forcing is on
    always_comb begin
        conv_word = analog_code;
        if (pat_s) begin
            if (dual_s) begin
                conv_word = `PATTERN_TWO_LANE;
            end else begin
                conv_word = `PATTERN_ONE_LANE;
            end
        end
    end

    // per-word pairing: one bit per edge, or two with lane B
    always_comb begin
        if (state_ff.dual) begin
            shifted = {state_ff.shift[13:0], 2'b00};
            edges_total = `EDGES_TWO_LANE;
        end else begin
            shifted = {state_ff.shift[14:0], 1'b0};
            edges_total = `EDGES_ONE_LANE;
        end
        edges_next = state_ff.edges + 5'h01;
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_state.cnv_prev = cnv_s;
        nxt_state.rclk_prev = rclk_s;

        // conversion sequencer
        case (state_ff.phase)
            CONV_IDLE: begin
                if (cnv_rise) begin
                    nxt_state.pending.data = analog_code;
                    nxt_state.phase = CONV_BUSY;
                    nxt_state.cnt = CONV_LOAD;
                end
            end
            CONV_BUSY: begin
                if (state_ff.cnt == 8'h00) begin
                    nxt_state.pending.data = pat_s ? conv_word : state_ff.pending.data;
                    nxt_state.pending.invalid = (state_ff.discard != 2'h0);
                    if (state_ff.discard != 2'h0) begin
                        nxt_state.discard = state_ff.discard - 2'h1;
                    end
                    nxt_state.phase = CONV_PUSH;
                end else begin
                    nxt_state.cnt = state_ff.cnt - 8'h01;
                end
            end
            CONV_PUSH: begin
                if (fifo_in_ready) begin
                    nxt_state.phase = CONV_ACQUIRE;
                    nxt_state.cnt = ACQ_LOAD;
                end
            end
            CONV_ACQUIRE: begin
                // a start edge during acquisition is still honoured
                if (cnv_rise) begin
                    nxt_state.pending.data = analog_code;
                    nxt_state.phase = CONV_BUSY;
                    nxt_state.cnt = CONV_LOAD;
                end else if (state_ff.cnt == 8'h00) begin
                    nxt_state.phase = CONV_IDLE;
                end else begin
                    nxt_state.cnt = state_ff.cnt - 8'h01;
                end
            end
            default: begin
                nxt_state.phase = CONV_IDLE;
            end
        endcase

        // serial readout
        nxt_state.echo = rclk_s;
        if (!state_ff.loaded) begin
            if (fifo_out_valid) begin
                nxt_state.loaded = 1'b1;
                nxt_state.dual = dual_s;
                nxt_state.shift = fifo_out_word.data;
                nxt_state.edges = 5'h00;
                nxt_state.invalid = fifo_out_word.invalid;
                nxt_state.lane_a = fifo_out_word.data[15];
                nxt_state.lane_b = dual_s ? fifo_out_word.data[14] : 1'b0;
            end
        end else if (rclk_edge) begin
            nxt_state.shift = shifted;
            nxt_state.edges = edges_next;
            nxt_state.lane_a = shifted[15];
            nxt_state.lane_b = state_ff.dual ? shifted[14] : 1'b0;
            if (edges_next == edges_total) begin
                nxt_state.loaded = 1'b0;
            end
        end

        nxt_state.lane_a_en = 1'b1;
        nxt_state.lane_b_en = dual_s;
        nxt_state.echo_en = 1'b1;

        // power-down overrides everything and rearms the discard count
        if (!pd_n_s) begin
            nxt_state.phase = CONV_IDLE;
            nxt_state.cnt = 8'h00;
            nxt_state.discard = `DISCARD_COUNT;
            nxt_state.loaded = 1'b0;
            nxt_state.shift = 16'h0000;
            nxt_state.edges = 5'h00;
            nxt_state.lane_a = 1'b0;
            nxt_state.lane_b = 1'b0;
            nxt_state.echo = 1'b0;
            nxt_state.lane_a_en = 1'b0;
            nxt_state.lane_b_en = 1'b0;
            nxt_state.echo_en = 1'b0;
            nxt_state.invalid = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            // power-on reset also rearms the discard of the first two results
            state_ff <= '0;
            state_ff.discard <= `DISCARD_COUNT;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign lane_a_data = state_ff.lane_a;
    assign lane_a_en = state_ff.lane_a_en;
    assign lane_b_data = state_ff.lane_b;
    assign lane_b_en = state_ff.lane_b_en;
    assign echoed_clock_out = state_ff.echo;
    assign echoed_clock_en = state_ff.echo_en;
    assign result_invalid = state_ff.invalid;
endmodule

// [bench/sar_adc_readout_chk.sv]
// Purpose: port-level checks of the converter readout block
// Assumes: inputs change at the falling edge of mclk
// Notes: latencies follow the two-flop input synchroniser
`timescale 1ns/1ps
module sar_adc_readout_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic power_down_n,
    input wire logic convert_start,
    input wire logic readout_clock,
    input wire logic dual_lane_select,
    input wire logic lane_a_data,
    input wire logic lane_a_en,
    input wire logic lane_b_en,
    input wire logic echoed_clock_out,
    input wire logic echoed_clock_en,
    input wire logic result_invalid
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_pd_held;
        (!power_down_n) [*4];
    endsequence
    sequence s_link_quiet;
        (power_down_n && $stable(readout_clock)) [*6];
    endsequence
    sequence s_all_quiet;
        (power_down_n && $stable(readout_clock) && !convert_start) [*8];
    endsequence
    a_pd_drivers_off: assert property (s_pd_held |-> !lane_a_en && !lane_b_en && !echoed_clock_en)
        else $error("driver enabled during power-down");
    a_pd_outputs_low: assert property (s_pd_held |-> !lane_a_data && !echoed_clock_out && !result_invalid)
        else $error("output active during power-down");
    a_lane_b_on: assert property ((power_down_n && dual_lane_select) [*5] |-> lane_b_en)
        else $error("second lane not enabled");
    a_lane_b_off: assert property ((!dual_lane_select) [*5] |-> !lane_b_en)
        else $error("second lane enabled in one-lane mode");
    a_echo_rise: assert property (lane_a_en && $rose(readout_clock) |-> ##[1:5] $rose(echoed_clock_out))
        else $error("echo missed a rising edge");
    a_echo_fall: assert property (lane_a_en && $fell(readout_clock) |-> ##[1:5] $fell(echoed_clock_out))
        else $error("echo missed a falling edge");
    a_echo_quiet: assert property (s_link_quiet |-> $stable(echoed_clock_out))
        else $error("echo moved without a clock edge");
    a_lanes_quiet: assert property (s_all_quiet |-> $stable(lane_a_data))
        else $error("lane moved without a clock edge");
endmodule

// [bench/adc_ctrl_model.sv]
// Purpose: controller that starts conversions and clocks results out
// Assumes: readout clock period 800 ns, idle low between bursts
// Notes: timeout_flag set when the echo does not follow the clock
`timescale 1ns/1ps
module adc_ctrl_model (
    input wire logic mclk,
    input wire logic lane_a_data,
    input wire logic lane_b_data,
    input wire logic echoed_clock_out,
    input wire logic result_invalid,
    output logic convert_start,
    output logic readout_clock,
    output logic timeout_flag
);
    initial begin
        convert_start = 1'b0;
        readout_clock = 1'b0;
        timeout_flag = 1'b0;
    end

    task automatic start_conv();
        @(negedge mclk);
        convert_start = 1'b1;
        repeat (4) @(negedge mclk);
        convert_start = 1'b0;
        repeat (4) @(negedge mclk);
    endtask

    // bits are taken in arrival order, just before each edge moves them on
    task automatic read_word(input logic dual, output logic [15:0] w, output logic inv);
        int bit_i;
        bit_i = 15;
        w = 16'h0000;
        repeat (4) @(negedge mclk);
        inv = result_invalid;
        for (int e = 0; e < (dual ? 8 : 16); e++) begin
            w[bit_i] = lane_a_data;
            if (dual) begin
                w[bit_i-1] = lane_b_data;
            end
            bit_i = bit_i - (dual ? 2 : 1);
            readout_clock = ~readout_clock;
            repeat (4) @(negedge mclk);
            if (echoed_clock_out !== readout_clock) begin
                timeout_flag = 1'b1;
            end
        end
    endtask
endmodule

// [bench/sar_adc_serial_readout_tb_top.sv]
// Purpose: self-checking bench of the converter readout block
// Assumes: 10 MHz mclk, controller model on the serial side
// Notes: inputs change at the falling edge
`timescale 1ns/1ps
module sar_adc_serial_readout_tb_top;
    localparam int FIFO_DEPTH = 32;
    localparam int FILL = FIFO_DEPTH + 2;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic power_down_n = 1'b1;
    logic dual_lane_select = 1'b0;
    logic pattern_force = 1'b0;
    logic [15:0] analog_code = 16'h0000;
    logic convert_start, readout_clock, lane_a_data, lane_a_en, lane_b_data, lane_b_en;
    logic echoed_clock_out, echoed_clock_en, result_invalid, timeout_flag;
    int error_cnt = 0;
    int n_compared = 0;

    always #50 mclk = ~mclk;

    sar_adc_serial_readout #(.FIFO_DEPTH(FIFO_DEPTH)) u_sar_adc_serial_readout (
        .mclk, .rst_n, .power_down_n, .convert_start, .readout_clock, .dual_lane_select,
        .pattern_force, .analog_code, .lane_a_data, .lane_a_en, .lane_b_data, .lane_b_en,
        .echoed_clock_out, .echoed_clock_en, .result_invalid);

    adc_ctrl_model u_adc_ctrl_model (.mclk, .lane_a_data, .lane_b_data, .echoed_clock_out,
        .result_invalid, .convert_start, .readout_clock, .timeout_flag);

    function automatic logic [15:0] code_of(input int i);
        return 16'h9A5C ^ 16'(i * 16'h0F25);
    endfunction

    task automatic finish_test();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk16(input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic chk1(input logic exp, input logic got);
        chk16({15'h0000, exp}, {15'h0000, got});
    endtask

    task automatic conv_read(input logic [15:0] code, input logic dual,
                             input logic [15:0] exp, input logic exp_inv);
        logic [15:0] w;
        logic inv;
        analog_code = code;
        u_adc_ctrl_model.start_conv();
        u_adc_ctrl_model.read_word(dual, w, inv);
        chk16(exp, w);
        chk1(exp_inv, inv);
        chk1(1'b0, timeout_flag);
        if (timeout_flag !== 1'b0) finish_test();
    endtask

    task automatic check_fresh(input int base);
        for (int i = 0; i < 3; i++) begin
            conv_read(code_of(base + i), 1'b0, code_of(base + i), i < 2);
        end
    endtask

    task automatic s_rearm(input logic by_reset, input int base);
        if (by_reset) rst_n = 1'b0;
        else power_down_n = 1'b0;
        repeat (4) @(negedge mclk);
        chk1(1'b0, lane_a_en);
        chk1(1'b0, echoed_clock_en);
        u_adc_ctrl_model.start_conv();
        chk1(1'b0, lane_a_data);
        rst_n = 1'b1;
        power_down_n = 1'b1;
        // settling wait shortened; the bench checks the code of all three results and expects the first two flagged invalid
        repeat (4) @(negedge mclk);
        check_fresh(base);
    endtask

    task automatic s_modes();
        dual_lane_select = 1'b1;
        repeat (6) @(negedge mclk);
        chk1(1'b1, lane_b_en);
        conv_read(16'h5AC3, 1'b1, 16'h5AC3, 1'b0);
        pattern_force = 1'b1;
        conv_read(16'h1234, 1'b1, 16'hCC3F, 1'b0);
        dual_lane_select = 1'b0;
        conv_read(16'h1234, 1'b0, 16'hA07F, 1'b0);
        pattern_force = 1'b0;
        chk1(1'b0, lane_b_en);
        conv_read(16'h1234, 1'b0, 16'h1234, 1'b0);
    endtask

    task automatic s_overlap();
        logic [15:0] w;
        logic inv;
        analog_code = 16'h3C96;
        u_adc_ctrl_model.start_conv();
        fork
            u_adc_ctrl_model.read_word(1'b0, w, inv);
            begin
                repeat (30) @(negedge mclk);
                analog_code = 16'hC369;
                u_adc_ctrl_model.start_conv();
            end
        join
        chk16(16'h3C96, w);
        u_adc_ctrl_model.read_word(1'b0, w, inv);
        chk16(16'hC369, w);
    endtask

    task automatic s_fifo();
        logic [15:0] w;
        logic inv;
        for (int i = 0; i < FILL; i++) begin
            analog_code = code_of(16 + i);
            u_adc_ctrl_model.start_conv();
        end
        analog_code = 16'hFFFF;
        u_adc_ctrl_model.start_conv(); // lost while the buffer is full
        for (int i = 0; i < FILL; i++) begin
            u_adc_ctrl_model.read_word(1'b0, w, inv);
            chk16(code_of(16 + i), w);
        end
        u_adc_ctrl_model.read_word(1'b0, w, inv);
        chk16(16'h0000, w);
    endtask

    initial begin
        repeat (10) @(negedge mclk);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        check_fresh(0);
        s_modes();
        s_overlap();
        s_fifo();
        s_rearm(1'b0, 60);
        s_rearm(1'b1, 70);
        finish_test();
    end

    initial begin
        repeat (60000) @(posedge mclk);
        error_cnt++;
        finish_test();
    end
endmodule

bind sar_adc_serial_readout sar_adc_readout_chk u_sar_adc_readout_chk (
    .mclk, .rst_n, .power_down_n, .convert_start, .readout_clock, .dual_lane_select,
    .lane_a_data, .lane_a_en, .lane_b_en, .echoed_clock_out, .echoed_clock_en,
    .result_invalid);
